//--- logic/jdap_port.v
/*
  Test access port with a small debug command register and the debug event
  pin logic. Every register runs on core_clk; the test clock is a pin that
  is synchronised and edge-detected, so the test clock must run well below
  half the core clock rate. Test reset is asynchronous in effect: it is
  synchronised but clears the controller without any test clock edge.
*/
// Overview of operation
// - Standard sixteen-state controller, instruction and data registers
// - Capture test data on test clock rise
// - Sample mode select on rise, advance
// - Drive data output only in shift states
// - Change data output only on falling edge
// - Test reset clears controller without clock edge
// - External debug event halts core, enters debug
// - Assert debug event three cycles on entry
// - Debug commands only through test port
`timescale 1ns/1ps
`include "jdap_regs.vh"

module jdap_port (
  // Core clock and synchronous chip reset.
  input  wire                   core_clk,
  input  wire                   sys_rst,
  // Test port pins.
  input  wire                   tck_pin,
  input  wire                   tms_pin,
  input  wire                   tdi_pin,
  input  wire                   trst_n_pin,
  output reg                    tdo_o,
  output reg                    tdo_oe,
  // Debug event pin, open drain and active low.
  input  wire                   debug_event_pin_i,
  output reg                    debug_event_pin_o,
  output reg                    debug_event_pin_oe,
  // Core handshake.
  output reg                    core_halt_req_q,
  input  wire                   core_halted,
  input  wire                   bkpt_hit,
  output reg                    dbg_mode_q,
  output reg  [`JDAP_DBG_W-1:0] dbg_cmd_q,
  output reg                    dbg_cmd_vld_q
);

  // One-hot codes of the sixteen test controller states.
  localparam [15:0] ST_RESET = 16'h0001;
  localparam [15:0] ST_IDLE  = 16'h0002;
  localparam [15:0] ST_SELDR = 16'h0004;
  localparam [15:0] ST_CAPDR = 16'h0008;
  localparam [15:0] ST_SHDR  = 16'h0010;
  localparam [15:0] ST_EX1DR = 16'h0020;
  localparam [15:0] ST_PADR  = 16'h0040;
  localparam [15:0] ST_EX2DR = 16'h0080;
  localparam [15:0] ST_UPDR  = 16'h0100;
  localparam [15:0] ST_SELIR = 16'h0200;
  localparam [15:0] ST_CAPIR = 16'h0400;
  localparam [15:0] ST_SHIR  = 16'h0800;
  localparam [15:0] ST_EX1IR = 16'h1000;
  localparam [15:0] ST_PAIR  = 16'h2000;
  localparam [15:0] ST_EX2IR = 16'h4000;
  localparam [15:0] ST_UPIR  = 16'h8000;

  // Two-stage synchronisers for every pin input.
  reg [1:0] tck_s, tms_s, tdi_s, trst_s, de_s;
  // Previous synchronised test clock, for edge detection.
  reg       tck_prev;
  // Controller state, one-hot.
  reg [15:0] st_q, st_d;
  // Instruction register and its shifter.
  reg [`JDAP_IR_W-1:0] ir_q, irsh_q;
  // Data shifters: bypass, identity and debug command.
  reg        byp_q;
  reg [31:0] id_q;
  reg [`JDAP_DBG_W-1:0] dbgsh_q;
  // Debug event pulse counter.
  reg [1:0]  de_cnt_q;
  // Core halt already seen, used to find the entry edge.
  reg        halted_prev;

  wire tck_rise = tck_s[1] & ~tck_prev;
  wire tck_fall = ~tck_s[1] & tck_prev;
  wire trst_n   = trst_s[1];
  wire tms      = tms_s[1];
  wire tdi      = tdi_s[1];

  // Returns the next state for a given state and mode select level.
  function [15:0] next_st;
    input [15:0] s;
    input        m;
    begin
      case (s)
        ST_RESET: next_st = m ? ST_RESET : ST_IDLE;
        ST_IDLE:  next_st = m ? ST_SELDR : ST_IDLE;
        ST_SELDR: next_st = m ? ST_SELIR : ST_CAPDR;
        ST_CAPDR: next_st = m ? ST_EX1DR : ST_SHDR;
        ST_SHDR:  next_st = m ? ST_EX1DR : ST_SHDR;
        ST_EX1DR: next_st = m ? ST_UPDR  : ST_PADR;
        ST_PADR:  next_st = m ? ST_EX2DR : ST_PADR;
        ST_EX2DR: next_st = m ? ST_UPDR  : ST_SHDR;
        ST_UPDR:  next_st = m ? ST_SELDR : ST_IDLE;
        ST_SELIR: next_st = m ? ST_RESET : ST_CAPIR;
        ST_CAPIR: next_st = m ? ST_EX1IR : ST_SHIR;
        ST_SHIR:  next_st = m ? ST_EX1IR : ST_SHIR;
        ST_EX1IR: next_st = m ? ST_UPIR  : ST_PAIR;
        ST_PAIR:  next_st = m ? ST_EX2IR : ST_PAIR;
        ST_EX2IR: next_st = m ? ST_UPIR  : ST_SHIR;
        ST_UPIR:  next_st = m ? ST_SELDR : ST_IDLE;
        // An illegal code falls back to the reset state.
        default:  next_st = ST_RESET;
      endcase
    end
  endfunction

  // Pins pass two flip-flops; reset values are the pull-up levels, except test clock and test reset, which reset low.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      tck_s    <= 2'h0;
      tms_s    <= 2'h3;
      tdi_s    <= 2'h3;
      trst_s   <= 2'h0;
      de_s     <= 2'h3;
      tck_prev <= 1'b0;
    end else begin
      tck_s    <= {tck_s[0], tck_pin};
      tms_s    <= {tms_s[0], tms_pin};
      tdi_s    <= {tdi_s[0], tdi_pin};
      trst_s   <= {trst_s[0], trst_n_pin};
      de_s     <= {de_s[0], debug_event_pin_i};
      tck_prev <= tck_s[1];
    end
  end

  // Next controller state.
  always @* begin
    st_d = st_q;
    if (!trst_n) begin
      st_d = ST_RESET;
    end else if (tck_rise) begin
      st_d = next_st(st_q, tms);
    end
  end

  // Controller and shift registers; shifts and updates happen on test clock rise, but test reset and the reset state reload the instruction without one.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      st_q    <= ST_RESET;
      ir_q    <= `JDAP_IR_IDCODE;
      irsh_q  <= {`JDAP_IR_W{1'b0}};
      byp_q   <= 1'b0;
      id_q    <= 32'h0;
      dbgsh_q <= {`JDAP_DBG_W{1'b0}};
      dbg_cmd_q     <= {`JDAP_DBG_W{1'b0}};
      dbg_cmd_vld_q <= 1'b0;
    end else begin
      st_q          <= st_d;
      dbg_cmd_vld_q <= 1'b0;
      if (!trst_n || (st_q == ST_RESET)) begin
        ir_q <= `JDAP_IR_IDCODE;
      end else if (tck_rise) begin
        case (st_q)
          ST_CAPIR: irsh_q <= `JDAP_IR_CAPTURE;
          ST_SHIR:  irsh_q <= {tdi, irsh_q[`JDAP_IR_W-1:1]};
          ST_UPIR:  ir_q   <= irsh_q;
          ST_CAPDR: begin
            byp_q   <= 1'b0;
            id_q    <= `JDAP_IDCODE;
            dbgsh_q <= {{(`JDAP_DBG_W-1){1'b0}}, dbg_mode_q};
          end
          ST_SHDR: begin
            byp_q   <= tdi;
            id_q    <= {tdi, id_q[31:1]};
            dbgsh_q <= {tdi, dbgsh_q[`JDAP_DBG_W-1:1]};
          end
          ST_UPDR: begin
            if (ir_q == `JDAP_IR_DEBUG) begin
              dbg_cmd_q     <= dbgsh_q;
              dbg_cmd_vld_q <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Serial output bit of the selected register.
  reg tdo_bit;
  always @* begin
    if (st_q == ST_SHIR) begin
      tdo_bit = irsh_q[0];
    end else if (ir_q == `JDAP_IR_IDCODE) begin
      tdo_bit = id_q[0];
    end else if (ir_q == `JDAP_IR_DEBUG) begin
      tdo_bit = dbgsh_q[0];
    end else begin
      tdo_bit = byp_q;
    end
  end

  // Data output is retimed to the falling edge so the host samples on rise.
  always @(posedge core_clk) begin
    if (sys_rst || !trst_n) begin
      tdo_o  <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_o  <= tdo_bit;
      tdo_oe <= (st_q == ST_SHIR) || (st_q == ST_SHDR);
    end
  end

  // Debug mode entry and the three-cycle acknowledge on the event pin.
  // The pin is not driven back into its own input: the pulse is masked
  // from the request path while it is being driven.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      core_halt_req_q    <= 1'b0;
      dbg_mode_q         <= 1'b0;
      halted_prev        <= 1'b0;
      de_cnt_q           <= 2'h0;
      debug_event_pin_o  <= 1'b0;
      debug_event_pin_oe <= 1'b0;
    end else begin
      halted_prev <= core_halted;
      dbg_mode_q  <= core_halted;
      // external event or breakpoint halts core
      // Our own acknowledge pulse still echoes out of the synchroniser for
      // two cycles after the drive ends; a halted core ignores requests, so
      // that echo cannot raise a stale request. A core that resumes within
      // those two cycles would see one, which is an accepted limitation.
      if (!core_halted && ((!de_s[1] && de_cnt_q == 2'h0) || bkpt_hit)) begin
        core_halt_req_q <= 1'b1;
      end else if (core_halted) begin
        core_halt_req_q <= 1'b0;
      end
      if (core_halted && !halted_prev) begin
        de_cnt_q           <= `JDAP_DE_CYCLES;
        debug_event_pin_oe <= 1'b1;
      end else if (de_cnt_q > 2'h1) begin
        de_cnt_q <= de_cnt_q - 2'h1;
      end else begin
        de_cnt_q           <= 2'h0;
        debug_event_pin_oe <= 1'b0;
      end
      debug_event_pin_o <= 1'b0;
    end
  end

endmodule // jdap_port

//--- logic/jdap_regs.vh
/*
  Constants for the test and debug access port: instruction codes and
  register widths, the identity word, and the debug event pulse length.
  Assumes it is included by its bare name from the design file.
*/
`ifndef JDAP_REGS_VH
`define JDAP_REGS_VH

// Instruction register width, capture pattern and codes.
`define JDAP_IR_W       4
`define JDAP_IR_CAPTURE 4'h1
`define JDAP_IR_IDCODE  4'h2
`define JDAP_IR_DEBUG   4'h7
`define JDAP_IR_BYPASS  4'hf

// Identity word; the value is arbitrary.
`define JDAP_IDCODE     32'h00000001
// Width of the debug command data register.
`define JDAP_DBG_W      8

// Debug event pulse length in core clock cycles.
`define JDAP_DE_CYCLES  2'h3

`endif

//--- tb/jdap_port_monitor.sv
/* Assertions on the port's pins and core handshake.
   Assumes a bind onto jdap_port and a test clock far below core_clk. */
`timescale 1ns/1ps
module jdap_mon (
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       sys_rst,
  // Test port pins.
  input wire logic       tck_pin,
  input wire logic       trst_n_pin,
  input wire logic       tdo_o,
  input wire logic       tdo_oe,
  // Event pin and core handshake.
  input wire logic       debug_event_pin_i,
  input wire logic       debug_event_pin_o,
  input wire logic       debug_event_pin_oe,
  input wire logic       core_halt_req_q,
  input wire logic       core_halted,
  input wire logic       dbg_cmd_vld_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Entry into debug, then exactly three driven cycles.
  sequence entry_s; $rose(core_halted); endsequence
  sequence pulse_s; debug_event_pin_oe [*3] ##1 !debug_event_pin_oe; endsequence
  de_pulse_a: assert property (entry_s |=> pulse_s)
    else $error("event pulse length wrong");
  de_cause_a: assert property ($rose(debug_event_pin_oe) |->
    $past(core_halted) && !$past(core_halted, 2)) else $error("event pulse without entry");
  de_low_a: assert property (debug_event_pin_oe |-> !debug_event_pin_o)
    else $error("event pin driven high");
  // The reset check must see the reset cycle itself, so it keeps no disable.
  rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=>
    !tdo_oe && !debug_event_pin_oe) else $error("pins driven in reset");
  tdo_fall_a: assert property ($changed(tdo_o) && tdo_oe |-> !$past(tck_pin, 2))
    else $error("data out moved off the falling edge");
  oe_start_a: assert property ($rose(tdo_oe) |-> !$past(tck_pin, 2))
    else $error("data out enabled off the falling edge");
  trst_clear_a: assert property (!trst_n_pin [*5] |-> !tdo_oe && !dbg_cmd_vld_q)
    else $error("test reset did not clear");
  halt_req_a: assert property ($fell(debug_event_pin_i) && !debug_event_pin_oe
    && !core_halted |-> ##[1:3] core_halt_req_q) else $error("no halt request");
  halt_drop_a: assert property (core_halted [*2] |-> !core_halt_req_q)
    else $error("halt request held");
  cmd_pulse_a: assert property (dbg_cmd_vld_q |=> !dbg_cmd_vld_q)
    else $error("command strobe too long");
endmodule // jdap_mon
bind jdap_port jdap_mon jdap_mon_inst (
  .core_clk           (core_clk),
  .sys_rst            (sys_rst),
  .tck_pin            (tck_pin),
  .trst_n_pin         (trst_n_pin),
  .tdo_o              (tdo_o),
  .tdo_oe             (tdo_oe),
  .debug_event_pin_i  (debug_event_pin_i),
  .debug_event_pin_o  (debug_event_pin_o),
  .debug_event_pin_oe (debug_event_pin_oe),
  .core_halt_req_q    (core_halt_req_q),
  .core_halted        (core_halted),
  .dbg_cmd_vld_q      (dbg_cmd_vld_q)
);

//--- tb/jdap_host.sv
/* Model of the external test controller driving the test port.
   Assumes core_clk at 40 ns; one test clock is 8 core cycles. */
`timescale 1ns/1ps
module jdap_host (
  // Timing reference.
  input  wire logic core_clk,
  // Test port pins.
  output logic      tck_pin,
  output logic      tms_pin,
  output logic      tdi_pin,
  output logic      trst_n_pin,
  input  wire logic tdo_o,
  input  wire logic tdo_oe,
  // Pulls the event pin low when set.
  output logic      de_req
);
  initial begin
    tck_pin = 1'b0;
    tms_pin = 1'b1;
    tdi_pin = 1'b1;
    trst_n_pin = 1'b0;
    de_req = 1'b0;
  end
  // The clock rests low between ticks and frames, matching the port's
  // reset level, so no stray edge is seen after a reset. Data changes with
  // the clock low and the output is read just before the rise.
  task automatic tick(input logic tm, input logic ti, output logic to);
    @(posedge core_clk) tms_pin <= tm;
    tdi_pin <= ti;
    repeat (3) @(posedge core_clk);
    #1 to = tdo_o;
    @(posedge core_clk) tck_pin <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(posedge core_clk) tck_pin <= 1'b0;
  endtask
  // Shift n bits, LSB first, leaving the shift state on the last.
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = 32'h0;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask
  // Mode select walk; data held at the pulled-up level.
  task automatic walk(input int n, input logic [7:0] seq);
    logic b;
    for (int i = 0; i < n; i++) tick(seq[i], 1'b1, b);
  endtask
  task automatic set_trst(input logic v);
    @(posedge core_clk) trst_n_pin <= v;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic event_req(input logic v);
    @(posedge core_clk) de_req <= v;
  endtask
endmodule // jdap_host

//--- tb/test_jdap_port.sv
/* Self-checking bench for the test and debug port.
   Assumes the host model in jdap_host and the monitor bind. */
`timescale 1ns/1ps
`include "jdap_regs.vh"
module test_jdap_port;
  logic       core_clk, sys_rst, core_halted, bkpt_hit, de_req;
  logic       tck_pin, tms_pin, tdi_pin, trst_n_pin, tdo_o, tdo_oe;
  logic       debug_event_pin_o, debug_event_pin_oe, core_halt_req_q, dbg_mode_q;
  logic [7:0] dbg_cmd_q;
  logic       dbg_cmd_vld_q, debug_event_pin_i;
  int         err_total = 0, n_tests = 0, vld_n = 0, oe_n = 0;
  // Pulled-up open-drain wire: low if either party pulls.
  assign debug_event_pin_i = !((debug_event_pin_oe && !debug_event_pin_o) || de_req);
  jdap_port jdap_port_inst (
    .core_clk           (core_clk),
    .sys_rst            (sys_rst),
    .tck_pin            (tck_pin),
    .tms_pin            (tms_pin),
    .tdi_pin            (tdi_pin),
    .trst_n_pin         (trst_n_pin),
    .tdo_o              (tdo_o),
    .tdo_oe             (tdo_oe),
    .debug_event_pin_i  (debug_event_pin_i),
    .debug_event_pin_o  (debug_event_pin_o),
    .debug_event_pin_oe (debug_event_pin_oe),
    .core_halt_req_q    (core_halt_req_q),
    .core_halted        (core_halted),
    .bkpt_hit           (bkpt_hit),
    .dbg_mode_q         (dbg_mode_q),
    .dbg_cmd_q          (dbg_cmd_q),
    .dbg_cmd_vld_q      (dbg_cmd_vld_q)
  );
  jdap_host jdap_host_inst (
    .core_clk   (core_clk),
    .tck_pin    (tck_pin),
    .tms_pin    (tms_pin),
    .tdi_pin    (tdi_pin),
    .trst_n_pin (trst_n_pin),
    .tdo_o      (tdo_o),
    .tdo_oe     (tdo_oe),
    .de_req     (de_req)
  );
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Pulses are counted here since they may land inside a host task.
  always @(posedge core_clk) begin
    if (dbg_cmd_vld_q === 1'b1) vld_n <= vld_n + 1;
    if (debug_event_pin_oe === 1'b1) oe_n <= oe_n + 1;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_reset;
    @(posedge core_clk) sys_rst <= 1'b1;
    @(posedge core_clk) sys_rst <= 1'b0;
    #1 check("tdo_oe", 0, tdo_oe);
    check("event oe", 0, debug_event_pin_oe);
  endtask
  task automatic t_ident;
    logic [31:0] d;
    jdap_host_inst.set_trst(1'b1);
    jdap_host_inst.walk(4, 8'h02);
    jdap_host_inst.shift(32, 32'h0, d);
    check("ident", `JDAP_IDCODE, d);
    jdap_host_inst.walk(2, 8'h01);
  endtask
  task automatic t_cmd;
    logic [31:0] d;
    int v0;
    v0 = vld_n;
    jdap_host_inst.walk(4, 8'h03);
    jdap_host_inst.shift(4, {28'h0, `JDAP_IR_DEBUG}, d);
    check("ir capture", `JDAP_IR_CAPTURE, d[3:0]);
    jdap_host_inst.walk(4, 8'h03);
    jdap_host_inst.shift(8, 32'ha5, d);
    check("dr capture", 0, d[0]);
    jdap_host_inst.walk(2, 8'h01);
    // The update lands on the rise of the walk's last tick; let the strobe pass.
    repeat (3) @(posedge core_clk);
    check("strobes", v0 + 1, vld_n);
    check("command", 8'ha5, dbg_cmd_q);
  endtask
  task automatic t_event;
    int k, o0;
    jdap_host_inst.event_req(1'b1);
    for (k = 0; k < 8 && core_halt_req_q !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    check("halt req", 1, core_halt_req_q);
    if (k == 8) conclude();
    jdap_host_inst.event_req(1'b0);
    o0 = oe_n;
    @(posedge core_clk) core_halted <= 1'b1;
    repeat (8) @(posedge core_clk);
    check("event cycles", o0 + 3, oe_n);
    check("mode", 1, dbg_mode_q);
    check("req drop", 0, core_halt_req_q);
    @(posedge core_clk) core_halted <= 1'b0;
    o0 = oe_n;
    @(posedge core_clk) bkpt_hit <= 1'b1;
    @(posedge core_clk) bkpt_hit <= 1'b0;
    core_halted <= 1'b1;
    repeat (8) @(posedge core_clk);
    check("break cycles", o0 + 3, oe_n);
    // Leave the core running so a later reset sees no false debug entry.
    @(posedge core_clk) core_halted <= 1'b0;
  endtask
  initial begin
    sys_rst = 1'b1;
    core_halted = 1'b0;
    bkpt_hit = 1'b0;
    t_reset;
    t_ident;
    t_cmd;
    t_event;
    t_reset;
    t_ident;
    conclude;
  end
endmodule // test_jdap_port
